// *** logic/tccc_channels.sv ***
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module tccc_channels (
    input wire logic clk, // Timer clock.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic [tccc_pkg::ADDR_W-1:0] addr, // Register address.
    input wire logic [7:0] wdata, // Write data.
    input wire logic wr_stb, // Write strobe.
    input wire logic rd_stb, // Read strobe.
    output logic [7:0] rdata, // Read data, cycle after the strobe.
    input wire logic [15:0] counter_value, // Shared counter value.
    input wire logic counter_step, // Counter took a new value.
    input wire logic counter_overflow, // Counter wrapped at modulo.
    input wire logic [tccc_pkg::CHANNELS-1:0] pin_in, // Channel pin levels.
    output logic [tccc_pkg::CHANNELS-1:0] pin_out, // Channel pin drive values.
    output logic [tccc_pkg::CHANNELS-1:0] pin_oe_n, // Low while driving a pin.
    output logic [tccc_pkg::CHANNELS-1:0] pin_is_gpio, // Pin left to port logic.
    output logic irq // Unmasked channel event pending.
);
    localparam int N = tccc_pkg::CHANNELS;

    // ========================================================
    // State
    // ========================================================
    logic buf0_reg;
    logic [N-1:0] msa_reg;
    logic [1:0] els_reg [N];
    logic [N-1:0] tov_reg, max_reg, max_eff_reg;
    logic [N-1:0] flag_reg, arm_reg;
    logic [N-1:0] cap_lock_reg, cmp_lock_reg;
    logic [15:0] val_reg [N];
    logic [15:0] act_cmp_reg;
    logic last_wr_reg;
    logic [N-1:0] pin_out_reg, pin_oe_n_reg, gpio_reg;
    logic [N-1:0] int_stat_reg, int_mask_reg;
    logic [7:0] rdata_reg;
    logic irq_reg;

    // ========================================================
    // Per-channel decode
    // ========================================================
    tccc_pkg::tccc_mode_t mode [N];
    logic [N-1:0] ch_off;
    logic [N-1:0] cap_mode, cmp_mode, sw_cmp;
    logic [N-1:0] edge_hit;
    logic [N-1:0] cap_evt, cmp_evt;
    logic [N-1:0] ovf_tgl, pol;
    logic [N-1:0] ctrl_wr, ctrl_rd, hi_wr, hi_rd, lo_wr, lo_rd;
    logic [15:0] cmp_val [N];
    logic [7:0] ctrl_view [N];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            // Channel one has no buffered bit and goes dark when channel zero buffers.
            assign ch_off[g] = (g == 1) && buf0_reg;
            assign mode[g] = tccc_pkg::chan_mode(ch_off[g], (g == 0) && buf0_reg,
                                                 msa_reg[g], els_reg[g]);
            assign cap_mode[g] = mode[g] == tccc_pkg::TCCC_CAPT;
            assign cmp_mode[g] = (mode[g] == tccc_pkg::TCCC_UNBUF) ||
                                 (mode[g] == tccc_pkg::TCCC_BUF);
            assign ctrl_wr[g] = wr_stb && !ch_off[g] &&
                                tccc_pkg::reg_hit(addr, g, tccc_pkg::OFS_CTRL);
            assign ctrl_rd[g] = rd_stb && tccc_pkg::reg_hit(addr, g, tccc_pkg::OFS_CTRL);
            assign hi_wr[g] = wr_stb && tccc_pkg::reg_hit(addr, g, tccc_pkg::OFS_HIGH);
            assign hi_rd[g] = rd_stb && tccc_pkg::reg_hit(addr, g, tccc_pkg::OFS_HIGH);
            assign lo_wr[g] = wr_stb && tccc_pkg::reg_hit(addr, g, tccc_pkg::OFS_LOW);
            assign lo_rd[g] = rd_stb && tccc_pkg::reg_hit(addr, g, tccc_pkg::OFS_LOW);

            tccc_edge u_edge (
                .clk(clk),
                .reset_n(reset_n),
                .pin_in(pin_in[g]),
                .rise_en(cap_mode[g] && els_reg[g][0]),
                .fall_en(cap_mode[g] && els_reg[g][1]),
                .edge_hit(edge_hit[g])
            );

            assign cap_evt[g] = edge_hit[g] && !cap_lock_reg[g];
            assign cmp_val[g] = (mode[g] == tccc_pkg::TCCC_BUF) ? act_cmp_reg : val_reg[g];
            // With select code zero and compare mode set, matches still flag but the pin stays free; while channel zero buffers, neither channel flags.
            assign sw_cmp[g] = (mode[g] == tccc_pkg::TCCC_PORT) && msa_reg[g] && !ch_off[g] &&
                               !((g == 0) && buf0_reg);
            assign cmp_evt[g] = (cmp_mode[g] || sw_cmp[g]) && counter_step && !cmp_lock_reg[g] &&
                                counter_value == cmp_val[g];
            assign ovf_tgl[g] = cmp_mode[g] && tov_reg[g] && counter_overflow;
            // Clear-on-compare pulses are active high, so that is polarity one.
            assign pol[g] = els_reg[g] == tccc_pkg::ELS_CLEAR;
            assign ctrl_view[g] = ch_off[g] ? 8'h00 :
                {flag_reg[g], 1'h0, (g == 0) && buf0_reg, msa_reg[g], els_reg[g],
                 tov_reg[g], max_reg[g]};

            // ================================================
            // Control fields
            // ================================================
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    msa_reg[g] <= 1'h0;
                    els_reg[g] <= tccc_pkg::ELS_OFF;
                    tov_reg[g] <= 1'h0;
                    max_reg[g] <= 1'h0;
                end else if (ctrl_wr[g]) begin
                    msa_reg[g] <= wdata[tccc_pkg::BIT_CMP];
                    els_reg[g] <= wdata[tccc_pkg::BIT_ELS_HI:tccc_pkg::BIT_ELS_LO];
                    tov_reg[g] <= wdata[tccc_pkg::BIT_TOV];
                    max_reg[g] <= wdata[tccc_pkg::BIT_MAX];
                end
            end

            // ================================================
            // Event flag: read with flag set, then write zero
            // ================================================
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    flag_reg[g] <= 1'h0;
                    arm_reg[g] <= 1'h0;
                end else if (cap_evt[g] || cmp_evt[g]) begin
                    flag_reg[g] <= 1'h1;
                    arm_reg[g] <= 1'h0;
                end else if (ctrl_wr[g] && !wdata[tccc_pkg::BIT_FLAG] && arm_reg[g]) begin
                    flag_reg[g] <= 1'h0;
                    arm_reg[g] <= 1'h0;
                end else if (ctrl_rd[g] && flag_reg[g]) begin
                    arm_reg[g] <= 1'h1;
                end
            end

            // ================================================
            // Channel value and byte-order locks
            // ================================================
            // No reset: the value is data and its content after reset is undefined.
            always_ff @(posedge clk) begin
                if (cap_evt[g]) begin
                    val_reg[g] <= counter_value;
                end else if (hi_wr[g]) begin
                    val_reg[g][15:8] <= wdata;
                end else if (lo_wr[g]) begin
                    val_reg[g][7:0] <= wdata;
                end
            end

            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    cap_lock_reg[g] <= 1'h0;
                end else if (lo_rd[g]) begin
                    cap_lock_reg[g] <= 1'h0;
                end else if (hi_rd[g] && cap_mode[g]) begin
                    cap_lock_reg[g] <= 1'h1;
                end
            end

            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    cmp_lock_reg[g] <= 1'h0;
                end else if (lo_wr[g]) begin
                    cmp_lock_reg[g] <= 1'h0;
                end else if (hi_wr[g] && (cmp_mode[g] || sw_cmp[g])) begin
                    cmp_lock_reg[g] <= 1'h1;
                end
            end

            // ================================================
            // Pin output
            // ================================================
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    pin_out_reg[g] <= tccc_pkg::OUT_RESET;
                    pin_oe_n_reg[g] <= 1'h1;
                    gpio_reg[g] <= 1'h1;
                    max_eff_reg[g] <= 1'h0;
                end else begin
                    gpio_reg[g] <= mode[g] == tccc_pkg::TCCC_PORT;
                    pin_oe_n_reg[g] <= !cmp_mode[g];
                    unique case (mode[g])
                        tccc_pkg::TCCC_PORT: begin
                            pin_out_reg[g] <= !msa_reg[g];
                            max_eff_reg[g] <= 1'h0;
                        end
                        tccc_pkg::TCCC_CAPT: begin
                            max_eff_reg[g] <= 1'h0;
                        end
                        tccc_pkg::TCCC_UNBUF, tccc_pkg::TCCC_BUF: begin
                            if (ovf_tgl[g]) begin
                                // Overflow opens a period and beats a same-cycle compare.
                                max_eff_reg[g] <= max_reg[g];
                                if (max_reg[g] || max_eff_reg[g]) begin
                                    pin_out_reg[g] <= pol[g];
                                end else begin
                                    pin_out_reg[g] <= !pin_out_reg[g];
                                end
                            end else if (cmp_evt[g] && !(max_eff_reg[g] && tov_reg[g])) begin
                                unique case (els_reg[g])
                                    tccc_pkg::ELS_TOGGLE: pin_out_reg[g] <= !pin_out_reg[g];
                                    tccc_pkg::ELS_CLEAR: pin_out_reg[g] <= 1'h0;
                                    tccc_pkg::ELS_SET: pin_out_reg[g] <= 1'h1;
                                    tccc_pkg::ELS_OFF: pin_out_reg[g] <= pin_out_reg[g];
                                endcase
                            end
                        end
                    endcase
                end
            end

            // ================================================
            // Checks
            // ================================================
            a_port_frees_pin: assert property (
                mode[g] == tccc_pkg::TCCC_PORT |=> pin_is_gpio[g] && pin_oe_n[g])
                else $error("port mode left pin driven");
            a_preset_level: assert property (
                mode[g] == tccc_pkg::TCCC_PORT |=> pin_out[g] == !$past(msa_reg[g]))
                else $error("preset level wrong");
            a_rise_only: assert property (
                (edge_hit[g] && els_reg[g] == tccc_pkg::ELS_TOGGLE) |-> pin_in[g])
                else $error("rising-only capture fired on fall");
            a_capture_load: assert property (
                cap_evt[g] |=> val_reg[g] == $past(counter_value) && flag_reg[g])
                else $error("capture lost value or flag");
            a_clear_on_cmp: assert property (
                (cmp_evt[g] && !ovf_tgl[g] && !max_eff_reg[g] &&
                 els_reg[g] == tccc_pkg::ELS_CLEAR) |=> !pin_out[g])
                else $error("clear on compare failed");
            a_ovf_priority: assert property (
                (ovf_tgl[g] && cmp_evt[g] && !max_reg[g] && !max_eff_reg[g])
                |=> pin_out[g] != $past(pin_out[g]))
                else $error("overflow toggle lost");
            a_max_hold: assert property (
                (max_eff_reg[g] && tov_reg[g] && cmp_mode[g] && !ovf_tgl[g])
                |=> pin_out[g] == $past(pin_out[g]))
                else $error("max duty level not held");
            a_max_level: assert property (
                (ovf_tgl[g] && (max_reg[g] || max_eff_reg[g])) |=> pin_out[g] == $past(pol[g]))
                else $error("max duty level wrong");
            a_cap_blocked: assert property (
                (cap_lock_reg[g] && !hi_wr[g] && !lo_wr[g]) |=> $stable(val_reg[g]))
                else $error("capture while high byte read");
            a_cmp_blocked: assert property (
                (hi_wr[g] && cmp_mode[g] && !lo_wr[g]) ##1 !lo_wr[g] |-> !cmp_evt[g])
                else $error("compare during byte write");
            a_flag_clear: assert property (
                $fell(flag_reg[g]) |-> $past(arm_reg[g] && ctrl_wr[g] && !wdata[7]))
                else $error("flag cleared without sequence");
            c_capture: cover property (cap_evt[g]);
            c_compare: cover property (cmp_evt[g] && pin_oe_n[g] == 1'h0);
            c_max_duty: cover property (max_eff_reg[g] && ovf_tgl[g]);
        end
    endgenerate

    // ========================================================
    // Buffered compare for channel zero
    // ========================================================
    // Two value registers alternate; the latest completed write is taken at the
    // period boundary; only a pending channel zero high byte holds it off, as channel one sets no lock.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            last_wr_reg <= 1'h0;
        end else if (lo_wr[1]) begin
            last_wr_reg <= 1'h1;
        end else if (lo_wr[0]) begin
            last_wr_reg <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!buf0_reg || (counter_overflow && !cmp_lock_reg[last_wr_reg])) begin
            act_cmp_reg <= val_reg[last_wr_reg];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            buf0_reg <= 1'h0;
        end else if (ctrl_wr[0]) begin
            buf0_reg <= wdata[tccc_pkg::BIT_BUF];
        end
    end

    a_ch1_released: assert property (
        buf0_reg |-> ctrl_view[1] == 8'h00 ##1 (pin_is_gpio[1] && pin_oe_n[1]))
        else $error("channel one active while buffering");
    c_buffered_load: cover property (buf0_reg && counter_overflow);

    // ========================================================
    // Interrupt status, mask and request
    // ========================================================
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            int_stat_reg <= tccc_pkg::INT_RESET;
        end else begin
            // A new event wins over a same-cycle write-one clear.
            int_stat_reg <= (int_stat_reg &
                ~((wr_stb && addr == tccc_pkg::ADDR_INT_STAT) ? wdata[N-1:0] : 2'h0)) |
                cap_evt | cmp_evt;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            int_mask_reg <= tccc_pkg::INT_RESET;
        end else if (wr_stb && addr == tccc_pkg::ADDR_INT_MASK) begin
            int_mask_reg <= wdata[N-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_reg <= 1'h0;
        end else begin
            irq_reg <= |(int_stat_reg & int_mask_reg);
        end
    end

    // ========================================================
    // Read port
    // ========================================================
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < N; i++) begin
            if (tccc_pkg::reg_hit(addr, i, tccc_pkg::OFS_CTRL)) rd_mux = ctrl_view[i];
            if (tccc_pkg::reg_hit(addr, i, tccc_pkg::OFS_HIGH)) rd_mux = val_reg[i][15:8];
            if (tccc_pkg::reg_hit(addr, i, tccc_pkg::OFS_LOW)) rd_mux = val_reg[i][7:0];
        end
        if (addr == tccc_pkg::ADDR_INT_STAT) rd_mux = {6'h00, int_stat_reg};
        if (addr == tccc_pkg::ADDR_INT_MASK) rd_mux = {6'h00, int_mask_reg};
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_reg <= tccc_pkg::RDATA_RESET;
        end else begin
            rdata_reg <= rd_stb ? rd_mux : 8'h00;
        end
    end

    assign rdata = rdata_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe_n = pin_oe_n_reg;
    assign pin_is_gpio = gpio_reg;
    assign irq = irq_reg;

endmodule // tccc_channels

// *** logic/tccc_pkg.sv ***
package tccc_pkg;

    // ========================================================
    // Geometry and register map
    // ========================================================
    localparam int CHANNELS = 2;
    localparam int ADDR_W = 4;
    localparam int CH_STRIDE = 3;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_HIGH = 4'h1;
    localparam logic [3:0] OFS_LOW = 4'h2;
    localparam logic [3:0] ADDR_INT_STAT = 4'h6;
    localparam logic [3:0] ADDR_INT_MASK = 4'h7;

    // ========================================================
    // Channel control field positions
    // ========================================================
    localparam int BIT_FLAG = 7;
    localparam int BIT_BUF = 5;
    localparam int BIT_CMP = 4;
    localparam int BIT_ELS_HI = 3;
    localparam int BIT_ELS_LO = 2;
    localparam int BIT_TOV = 1;
    localparam int BIT_MAX = 0;

    // ========================================================
    // Codes and reset values
    // ========================================================
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;
    localparam logic OUT_RESET = 1'h1;
    localparam logic [1:0] INT_RESET = 2'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    typedef enum logic [3:0] {
        TCCC_PORT = 4'h1,
        TCCC_CAPT = 4'h2,
        TCCC_UNBUF = 4'h4,
        TCCC_BUF = 4'h8
    } tccc_mode_t;

    function automatic tccc_mode_t chan_mode(input logic off, input logic bm,
                                             input logic cm, input logic [1:0] els);
        if (off || els == ELS_OFF) return TCCC_PORT;
        if (bm) return TCCC_BUF;
        if (cm) return TCCC_UNBUF;
        return TCCC_CAPT;
    endfunction

    function automatic logic reg_hit(input logic [3:0] a, input int ch, input logic [3:0] ofs);
        return a == (4'(ch * CH_STRIDE) + ofs);
    endfunction

endpackage

// *** logic/tccc_edge.sv ***
`timescale 1ns/1ps
module tccc_edge (
    input wire logic clk, // Timer clock.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic pin_in, // Channel pin level.
    input wire logic rise_en, // Rising edges are active.
    input wire logic fall_en, // Falling edges are active.
    output logic edge_hit // Active edge seen this cycle.
);
    // ========================================================
    // Edge detection
    // ========================================================
    logic prev_reg;

    // Clearing to low means a pin held high at reset shows one spurious rise.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prev_reg <= 1'h0;
        end else begin
            prev_reg <= pin_in;
        end
    end

    assign edge_hit = (pin_in & ~prev_reg & rise_en) | (~pin_in & prev_reg & fall_en);

endmodule // tccc_edge

// *** tb/tccc_pin_model.sv ***
`timescale 1ns/1ps
// ========================================
// Outside source on the channel pins.
// A pin that the block releases shows the outside level, as a pull-up would hold it.
module tccc_pin_model (
    input wire logic [tccc_pkg::CHANNELS-1:0] drive_level, // Outside level.
    input wire logic [tccc_pkg::CHANNELS-1:0] pin_out, // Block drive values.
    input wire logic [tccc_pkg::CHANNELS-1:0] pin_oe_n, // Low while block drives.
    output logic [tccc_pkg::CHANNELS-1:0] pin_in // Resolved pin levels.
);
    assign pin_in = (pin_oe_n & drive_level) | (~pin_oe_n & pin_out);
endmodule // tccc_pin_model

// *** tb/tccc_channels_tb.sv ***
`timescale 1ns/1ps
module tccc_channels_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [tccc_pkg::ADDR_W-1:0] addr = '0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rdata;
    logic [15:0] counter_value = 16'h0000;
    logic counter_step = 1'b0;
    logic counter_overflow = 1'b0;
    logic [1:0] drive_level = 2'h3;
    logic [1:0] pin_in;
    logic [1:0] pin_out;
    logic [1:0] pin_oe_n;
    logic [1:0] pin_is_gpio;
    logic irq;
    int miscompares = 0;
    int n_tests = 0;

    always #25 clk = ~clk;

    tccc_channels DUT (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .counter_value(counter_value),
        .counter_step(counter_step), .counter_overflow(counter_overflow), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_is_gpio(pin_is_gpio), .irq(irq));
    tccc_pin_model pins (.drive_level(drive_level), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_in(pin_in));

    // ========================================
    // Bus, counter and compare helpers
    task automatic summarize();
        $display("counts: tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chkp(input logic [1:0] e, input logic [1:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: pins expected %h got %h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        rd(a);
        chk8(e, rdata);
    endtask
    task automatic clr(input logic [3:0] a, input logic [7:0] c);
        rd(a);
        wr(a, c);
    endtask
    task automatic wv(input logic [3:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 4'h1, v[7:0]);
    endtask
    task automatic st();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic pin(input int ch, input logic v);
        @(posedge clk);
        drive_level[ch] <= v;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Overflow comes with FFFF, which matches no compare value used here, except once with 0200 to meet a same-cycle compare.
    task automatic evp(input logic [15:0] v, input logic ov, input logic e);
        @(posedge clk);
        counter_value <= v;
        counter_step <= 1'b1;
        counter_overflow <= ov;
        @(posedge clk);
        counter_step <= 1'b0;
        counter_overflow <= 1'b0;
        #1;
        chkp({1'b0, e}, {1'b0, pin_out[0]});
    endtask

    // ========================================
    // Scenarios
    task automatic t_reset();
        chkp(2'h3, pin_oe_n);
        chkp(2'h3, pin_is_gpio);
        chkp(2'h0, {1'b0, irq});
        rdc(4'h0, 8'h00);
        rdc(4'h3, 8'h00);
        rdc(4'h8, 8'h00);
        wr(4'h0, 8'h10);
        st();
        chkp(2'h2, pin_out);
        chkp(2'h3, pin_is_gpio);
        wr(4'h0, 8'h00);
        st();
        chkp(2'h3, pin_out);
    endtask
    task automatic t_capture();
        logic [1:0] c;
        wr(4'h7, 8'h02);
        for (int i = 1; i < 4; i++) begin
            c = 2'(i);
            clr(4'h3, {4'h0, c, 2'h0});
            pin(1, 1'b0);
            rdc(4'h3, {c[1], 3'h0, c, 2'h0});
            clr(4'h3, {4'h0, c, 2'h0});
            pin(1, 1'b1);
            rdc(4'h3, {c[0], 3'h0, c, 2'h0});
            clr(4'h3, {4'h0, c, 2'h0});
        end
        evp(16'hA5C3, 1'b0, 1'b1);
        pin(1, 1'b0);
        rdc(4'h4, 8'hA5);
        evp(16'h0F0F, 1'b0, 1'b1);
        pin(1, 1'b1);
        rdc(4'h5, 8'hC3);
        pin(1, 1'b0);
        rdc(4'h4, 8'h0F);
        rdc(4'h5, 8'h0F);
        chkp(2'h1, {1'b0, irq});
        wr(4'h7, 8'h00);
        st();
        chkp(2'h0, {1'b0, irq});
        wr(4'h7, 8'h02);
        st();
        chkp(2'h1, {1'b0, irq});
        wr(4'h6, 8'h02);
        st();
        chkp(2'h0, {1'b0, irq});
    endtask
    task automatic t_compare();
        wv(4'h1, 16'h0100);
        wr(4'h0, 8'h1C);
        st();
        chkp(2'h0, {1'b0, pin_oe_n[0]});
        evp(16'h0100, 1'b0, 1'b1);
        wr(4'h0, 8'h18);
        evp(16'h0100, 1'b0, 1'b0);
        wr(4'h0, 8'h14);
        evp(16'h0100, 1'b0, 1'b1);
        evp(16'h0100, 1'b0, 1'b0);
        wr(4'h0, 8'h10);
        evp(16'h0100, 1'b0, 1'b0);
        rdc(4'h0, 8'h90);
        wr(4'h0, 8'h90);
        rdc(4'h0, 8'h90);
        wr(4'h0, 8'h10);
        rdc(4'h0, 8'h10);
        evp(16'h0100, 1'b0, 1'b0);
        rdc(4'h0, 8'h90);
        wr(4'h0, 8'h1C);
        wr(4'h1, 8'h02);
        evp(16'h0200, 1'b0, 1'b0);
        wr(4'h2, 8'h00);
        evp(16'h0200, 1'b0, 1'b1);
        wr(4'h0, 8'h1E);
        evp(16'h0200, 1'b1, 1'b0);
        evp(16'hFFFF, 1'b1, 1'b1);
        wr(4'h0, 8'h1B);
        evp(16'h0200, 1'b0, 1'b0);
        evp(16'hFFFF, 1'b1, 1'b1);
        evp(16'h0200, 1'b0, 1'b1);
        wr(4'h0, 8'h1A);
        evp(16'h0200, 1'b0, 1'b1);
        evp(16'hFFFF, 1'b1, 1'b1);
        evp(16'h0200, 1'b0, 1'b0);
        wr(4'h0, 8'h1F);
        evp(16'hFFFF, 1'b1, 1'b0);
        evp(16'hFFFF, 1'b1, 1'b0);
    endtask
    task automatic t_buffered();
        wv(4'h1, 16'h0040);
        wr(4'h0, 8'h28);
        wr(4'h3, 8'h1C);
        rdc(4'h3, 8'h00);
        st();
        chkp(2'h2, pin_is_gpio);
        evp(16'hFFFF, 1'b1, 1'b0);
        wr(4'h0, 8'h2C);
        evp(16'h0040, 1'b0, 1'b1);
        wr(4'h0, 8'h28);
        wv(4'h4, 16'h0050);
        evp(16'hFFFF, 1'b1, 1'b1);
        evp(16'h0040, 1'b0, 1'b1);
        evp(16'h0050, 1'b0, 1'b0);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        st();
        t_reset();
        t_capture();
        t_compare();
        t_buffered();
        summarize();
    end
    initial begin
        #1000000;
        miscompares++;
        summarize();
    end
endmodule // tccc_channels_tb
